/* adc_seq_defs.vh */
// constants for the converter sequencing block
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
`define NORMAL_CYCLES     5'h0d
`define FIRST_CYCLES      5'h19
`define SAMPLE_NORMAL     5'h01
`define SAMPLE_FIRST      5'h0d
`define FULL_SCALE        10'h3ff
`define ZERO_CODE         10'h000
`define CODE_SPAN         11'h400
`define MUX_TEMP_SENSOR   4'h8
`define MUX_BANDGAP       4'he
`define MUX_GROUND        4'hf
`define REF_EXTERNAL      2'h0
`define REF_SUPPLY        2'h1
`define REF_RESERVED      2'h2
`define REF_INTERNAL      2'h3
`define PRESCALE_W        7
`endif

/* adc_prescaler.v */
// converter clock prescaler: one-cycle tick per converter clock edge
`timescale 1ns/1ns
`include "adc_seq_defs.vh"
module adc_prescaler (
  input  wire       clk,
  input  wire       rstn,
  input  wire       run,
  input  wire [2:0] div_sel,
  output reg        tick
);
  reg  [`PRESCALE_W-1:0] cnt_r;
  reg  [`PRESCALE_W-1:0] limit;

  always @* begin
    case (div_sel)
      3'h0, 3'h1: limit = 7'h01;
      3'h2:       limit = 7'h03;
      3'h3:       limit = 7'h07;
      3'h4:       limit = 7'h0f;
      3'h5:       limit = 7'h1f;
      3'h6:       limit = 7'h3f;
      default:    limit = 7'h7f;
    endcase
  end

  // held in reset while the converter is off
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 7'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= 7'h00;
      tick  <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r <= 7'h00;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      tick  <= 1'b0;
    end
  end
endmodule

/* adc_conversion_sequencing.v */
// converter sequencing: start, timing, selection lock, result coding, sleep start
`timescale 1ns/1ns
`include "adc_seq_defs.vh"
module adc_conversion_sequencing (
  input  wire       clk,
  input  wire       rstn,
  input  wire       converter_enable_bit,
  input  wire       conversion_start_wr,
  input  wire       free_run,
  input  wire       done_irq_enable,
  input  wire       done_flag_clear,
  input  wire [2:0] prescale_sel,
  input  wire [3:0] input_channel_field,
  input  wire [1:0] ref_sel,
  input  wire       left_adjust,
  input  wire       low_byte_read,
  input  wire       high_byte_read,
  input  wire       core_halted,
  input  wire       sleep_noise_reduce,
  input  wire       sleep_idle,
  input  wire [9:0] sar_code,
  input  wire       sar_overrange,
  output reg        conversion_start_bit,
  output reg        conversion_done_flag,
  output reg        done_irq,
  output reg  [7:0] result_low_byte,
  output reg  [7:0] result_high_byte,
  output reg  [3:0] active_channel,
  output reg  [1:0] active_ref,
  output reg        temp_sensor_on,
  output reg        internal_ref_on,
  output reg        supply_ref_on,
  output reg        sample_hold,
  output reg        analog_on
);
  localparam S_IDLE = 3'b001;
  localparam S_CONV = 3'b010;
  localparam S_LAST = 3'b100;

  reg  [2:0] state_r;
  reg  [4:0] cnt_r;
  reg        first_r;
  reg        start_pend_r;
  reg        lock_r;
  reg        halt_s1_r;
  reg        halt_s2_r;
  reg        halt_d_r;
  reg        sleep_armed_r;
  reg  [9:0] data_r;
  reg        rd_block_r;
  wire       tick;
  wire       halt_rise;
  wire [9:0] coded;
  wire [4:0] total;

  adc_prescaler u_pre (
    .clk     (clk),
    .rstn    (rstn),
    .run     (converter_enable_bit),
    .div_sel (prescale_sel),
    .tick    (tick)
  );

  // core halt arrives from another domain
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halt_s1_r <= 1'b0;
      halt_s2_r <= 1'b0;
      halt_d_r  <= 1'b0;
    end else begin
      halt_s1_r <= core_halted;
      halt_s2_r <= halt_s1_r;
      halt_d_r  <= halt_s2_r;
    end
  end
  assign halt_rise = halt_s2_r & ~halt_d_r;

  // other sleep states do not touch the enable
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      sleep_armed_r <= 1'b0;
    else
      sleep_armed_r <= (sleep_noise_reduce | sleep_idle) & converter_enable_bit &
                       ~free_run & done_irq_enable;
  end

  // saturate rather than wrap above the reference
  assign coded = sar_overrange ? `FULL_SCALE : sar_code;
  assign total = first_r ? `FIRST_CYCLES : `NORMAL_CYCLES;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r              <= S_IDLE;
      cnt_r                <= 5'h00;
      first_r              <= 1'b1;
      start_pend_r         <= 1'b0;
      conversion_start_bit <= 1'b0;
      conversion_done_flag <= 1'b0;
      done_irq             <= 1'b0;
      data_r               <= `ZERO_CODE;
      rd_block_r           <= 1'b0;
      sample_hold          <= 1'b0;
    end else if (!converter_enable_bit) begin
      state_r              <= S_IDLE;
      cnt_r                <= 5'h00;
      first_r              <= 1'b1;
      start_pend_r         <= 1'b0;
      conversion_start_bit <= 1'b0;
      sample_hold          <= 1'b0;
      if (done_flag_clear)
        conversion_done_flag <= 1'b0;
      done_irq <= conversion_done_flag & ~done_flag_clear & done_irq_enable;
    end else begin
      sample_hold <= 1'b0;
      if (high_byte_read)
        rd_block_r <= 1'b0;
      else if (low_byte_read)
        rd_block_r <= 1'b1;
      // start waits for the next converter clock edge
      if (conversion_start_wr || (halt_rise && sleep_armed_r && state_r == S_IDLE)) begin
        start_pend_r         <= 1'b1;
        conversion_start_bit <= 1'b1;
      end
      case (state_r)
        S_IDLE: begin
          if (tick && start_pend_r) begin
            start_pend_r <= 1'b0;
            cnt_r        <= 5'h01;
            state_r      <= S_CONV;
          end
        end
        S_CONV: begin
          if (tick) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == (first_r ? `SAMPLE_FIRST : `SAMPLE_NORMAL))
              sample_hold <= 1'b1;
            if (cnt_r == total - 5'h01)
              state_r <= S_LAST;
          end
        end
        S_LAST: begin
          if (tick) begin
            // 13 or 25 converter clocks from start to done
            first_r <= 1'b0;
            if (!rd_block_r)
              data_r <= coded;
            if (free_run) begin
              cnt_r   <= 5'h01;
              state_r <= S_CONV;
            end else begin
              cnt_r                <= 5'h00;
              state_r              <= S_IDLE;
              conversion_start_bit <= conversion_start_wr;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
      // set wins over clear; raised even when a sleep start was interrupted
      if (state_r == S_LAST && tick)
        conversion_done_flag <= 1'b1;
      else if (done_flag_clear)
        conversion_done_flag <= 1'b0;
      done_irq <= ((state_r == S_LAST && tick) | (conversion_done_flag & ~done_flag_clear)) &
                  done_irq_enable;
    end
  end

  // selection lock between start and the last converter clock
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      lock_r <= 1'b0;
    else
      lock_r <= (state_r == S_CONV) & converter_enable_bit;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_channel  <= 4'h0;
      active_ref      <= `REF_EXTERNAL;
      temp_sensor_on  <= 1'b0;
      internal_ref_on <= 1'b0;
      supply_ref_on   <= 1'b0;
      analog_on       <= 1'b0;
    end else begin
      analog_on <= converter_enable_bit;
      if (!lock_r && state_r != S_CONV) begin
        active_channel  <= input_channel_field;
        active_ref      <= ref_sel;
        temp_sensor_on  <= (input_channel_field == `MUX_TEMP_SENSOR);
        internal_ref_on <= (ref_sel == `REF_INTERNAL);
        supply_ref_on   <= (ref_sel == `REF_SUPPLY);
      end
    end
  end

  // result presentation follows the adjust bit at once
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_low_byte  <= 8'h00;
      result_high_byte <= 8'h00;
    end else if (left_adjust) begin
      result_low_byte  <= {data_r[1:0], 6'h00};
      result_high_byte <= data_r[9:2];
    end else begin
      result_low_byte  <= data_r[7:0];
      result_high_byte <= {6'h00, data_r[9:8]};
    end
  end
endmodule

/* adc_seq_checker_assertions.sv */
// assertion checker for the converter sequencing block
`timescale 1ns/1ns
module adc_seq_checker (
  input wire       clk,
  input wire       rstn,
  input wire       converter_enable_bit,
  input wire       free_run,
  input wire       done_irq_enable,
  input wire       core_halted,
  input wire       sleep_noise_reduce,
  input wire       sleep_idle,
  input wire       conversion_start_bit,
  input wire       conversion_done_flag,
  input wire       done_irq,
  input wire [3:0] active_channel,
  input wire [1:0] active_ref,
  input wire       temp_sensor_on,
  input wire       internal_ref_on,
  input wire       sample_hold,
  input wire       analog_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_sensor_route: assert property (
    active_channel == 4'h8 && $past(active_channel) == 4'h8 |-> temp_sensor_on)
    else $error("temperature sensor not routed");
  a_internal_ref_sel: assert property (
    active_ref == 2'h3 && $past(active_ref) == 2'h3 |-> internal_ref_on)
    else $error("internal reference not selected");
  a_sel_frozen: assert property (
    sample_hold |=> ($stable(active_channel) && $stable(active_ref)) [*8])
    else $error("selection moved during conversion");
  a_single_done_idle: assert property (
    $rose(conversion_done_flag) && !free_run |-> !conversion_start_bit)
    else $error("busy still high after single conversion");
  a_free_run_busy: assert property (
    $rose(conversion_done_flag) && free_run |-> conversion_start_bit)
    else $error("free run stopped after completion");
  a_done_irq_level: assert property (
    conversion_done_flag && done_irq_enable
    && $past(conversion_done_flag && done_irq_enable) |-> done_irq)
    else $error("done request missing");
  a_sleep_start: assert property (
    $rose(core_halted) && converter_enable_bit && !free_run && done_irq_enable
    && (sleep_noise_reduce || sleep_idle) && !conversion_start_bit
    |-> ##[3:6] conversion_start_bit)
    else $error("no conversion after core halt");
  a_stay_enabled: assert property (
    converter_enable_bit && $past(converter_enable_bit) && $past(rstn) |-> analog_on)
    else $error("converter switched off while enabled");
  cover property ($rose(conversion_done_flag) && free_run);
  cover property ($rose(done_irq));
  cover property ($rose(core_halted) && sleep_noise_reduce);
endmodule
bind adc_conversion_sequencing adc_seq_checker i_chk (
  .clk(clk), .rstn(rstn), .converter_enable_bit(converter_enable_bit),
  .free_run(free_run), .done_irq_enable(done_irq_enable), .core_halted(core_halted),
  .sleep_noise_reduce(sleep_noise_reduce), .sleep_idle(sleep_idle),
  .conversion_start_bit(conversion_start_bit), .conversion_done_flag(conversion_done_flag),
  .done_irq(done_irq), .active_channel(active_channel), .active_ref(active_ref),
  .temp_sensor_on(temp_sensor_on), .internal_ref_on(internal_ref_on),
  .sample_hold(sample_hold), .analog_on(analog_on));

/* adc_conversion_sequencing_tb.sv */
// self-checking bench for the converter sequencing block
`timescale 1ns/1ns
module adc_conversion_sequencing_tb;
  reg        clk, rstn, en, wr, fr, ie, clr, lrd, hrd, halt, snr, sid, ladj, ovr;
  reg  [2:0] psel;
  reg  [3:0] ch;
  reg  [1:0] rs;
  reg  [9:0] code;
  wire       busy, flag, irq, ts_on, ir_on, sr_on, sh, an_on;
  wire [7:0] lo, hi;
  wire [3:0] ach;
  wire [1:0] reference_pin;
  integer    err_count, samples_checked, n;
  integer    sh_count = 0;
  adc_conversion_sequencing i_dut (
    .clk(clk), .rstn(rstn), .converter_enable_bit(en), .conversion_start_wr(wr),
    .free_run(fr), .done_irq_enable(ie), .done_flag_clear(clr), .prescale_sel(psel),
    .input_channel_field(ch), .ref_sel(rs), .left_adjust(ladj), .low_byte_read(lrd),
    .high_byte_read(hrd), .core_halted(halt), .sleep_noise_reduce(snr),
    .sleep_idle(sid), .sar_code(code), .sar_overrange(ovr),
    .conversion_start_bit(busy), .conversion_done_flag(flag), .done_irq(irq),
    .result_low_byte(lo), .result_high_byte(hi), .active_channel(ach),
    .active_ref(reference_pin), .temp_sensor_on(ts_on), .internal_ref_on(ir_on),
    .supply_ref_on(sr_on), .sample_hold(sh), .analog_on(an_on));
  task final_report;
    begin
      if (err_count == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
    end
  endtask
  task step(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  // read the byte pair, clear the flag, then request a conversion
  task start;
    begin
      lrd = 1; step(1); lrd = 0; hrd = 1; step(1); hrd = 0;
      clr = 1; step(1); clr = 0; wr = 1; step(1); wr = 0;
    end
  endtask
  task wait_done;
    begin
      n = 1;
      while (flag !== 1'b1 && n < 200) begin
        step(1);
        n = n + 1;
      end
      if (flag !== 1'b1)
        err_count = err_count + 1;
    end
  endtask
  // count sample-and-hold pulses, one per conversion
  always @(posedge clk) begin
    if (sh)
      sh_count <= sh_count + 1;
  end
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    err_count = err_count + 1;
    final_report;
  end
  initial begin
    {rstn, en, wr, fr, ie, clr, lrd, hrd, halt, snr, sid, ladj, ovr} = 0;
    psel = 3'h0; ch = 4'h8; rs = 2'h3; code = 10'h2a5;
    err_count = 0; samples_checked = 0;
    step(8); rstn = 1; step(2); en = 1; ie = 1; step(2);
    start; step(6); ch = 4'h5; step(2);
    check(ach, 4'h8);
    check(ts_on, 1'b1);
    check(ir_on, 1'b1);
    wait_done;
    // eight edges have passed since the start edge before the wait began
    check(n + 7 >= 2 * 25 + 1 && n + 7 <= 2 * 25 + 2, 1'b1);
    step(2);
    check({hi, lo}, 16'h02a5);
    check(irq, 1'b1);
    check(ach, 4'h5);
    code = 10'h000; start; wait_done;
    check(n - 1 >= 2 * 13 + 1 && n - 1 <= 2 * 13 + 2, 1'b1);
    step(2);
    check({hi, lo}, 16'h0000);
    ovr = 1; ladj = 1; start; wait_done; step(2);
    check({hi, lo}, 16'hffc0);
    ovr = 0; ladj = 0; fr = 1; ch = 4'h1; rs = 2'h1; start; wait_done; ch = 4'h2; step(4);
    check(ach, 4'h1);
    check(reference_pin, 2'h1);
    check(sr_on, 1'b1);
    check(ir_on, 1'b0);
    clr = 1; step(1); clr = 0; wait_done; step(4);
    check(ach, 4'h2);
    check(busy, 1'b1);
    fr = 0; clr = 1; step(1); clr = 0; wait_done; step(3);
    clr = 1; step(1); clr = 0; snr = 1; halt = 1; n = 0;
    while (busy !== 1'b1 && n < 12) begin
      step(1);
      n = n + 1;
    end
    check(n <= 8, 1'b1);
    halt = 0; wait_done; step(2);
    check(irq, 1'b1);
    snr = 0; step(2); halt = 1; step(10);
    check(an_on, 1'b1);
    check(busy, 1'b0);
    halt = 0; clr = 1; step(3); clr = 0; sid = 1; halt = 1; step(4);
    check(busy, 1'b1);
    halt = 0; sid = 0; wait_done; step(2);
    check(irq, 1'b1);
    check(sh_count, 16'h0008);
    en = 0; step(3);
    check(an_on, 1'b0);
    final_report;
  end
endmodule
